//--- hdl/dapr_pkg.sv
package dapr_pkg;
  // register byte offsets
  localparam logic [7:0] DAPR_OFF_CMD = 8'h00;
  localparam logic [7:0] DAPR_OFF_TIMING = 8'h04;
  localparam logic [7:0] DAPR_OFF_MODE = 8'h08;
  localparam logic [7:0] DAPR_OFF_BANK_STAT = 8'h0c;
  localparam logic [7:0] DAPR_OFF_REF_ROW = 8'h10;
  localparam logic [7:0] DAPR_OFF_REF_CNT = 8'h14;
  // command word fields
  localparam int DAPR_CMD_BANK_LSB = 0;
  localparam int DAPR_CMD_FLAG_POS = 3;
  localparam int DAPR_CMD_CS_N_POS = 4;
  localparam int DAPR_CMD_RAS_N_POS = 5;
  localparam int DAPR_CMD_CAS_N_POS = 6;
  localparam int DAPR_CMD_WE_N_POS = 7;
  // timing register fields, each 4 bits, in clocks
  localparam int DAPR_TIM_RAS_LSB = 0;
  localparam int DAPR_TIM_RTP_LSB = 4;
  localparam int DAPR_TIM_RP_LSB = 8;
  localparam int DAPR_TIM_RFC_LSB = 12;
  // mode register fields
  localparam int DAPR_MODE_BL8_POS = 0;
  localparam int DAPR_MODE_AL_LSB = 4;
  localparam int DAPR_MODE_WL_LSB = 8;
  localparam int DAPR_MODE_WR_LSB = 12;
  // reset values, write recovery limits and prefetch gap
  localparam logic [15:0] DAPR_TIMING_RST = 16'h8328;
  localparam logic [15:0] DAPR_MODE_RST = 16'h3200;
  localparam logic [3:0] DAPR_WR_MIN = 4'h2;
  localparam logic [3:0] DAPR_WR_MAX = 4'h6;
  localparam logic [3:0] DAPR_PREFETCH_GAP = 4'h2;
  // refresh interval figures
  localparam int DAPR_CLOCK_MHZ = 50;
  localparam int DAPR_REFI_NS = 7800;
  localparam int DAPR_REFI_CYCLES = (DAPR_REFI_NS * DAPR_CLOCK_MHZ) / 1000;
  // bank state machine
  typedef enum logic [2:0] {
    DAPR_IDLE = 3'b000,
    DAPR_ACTIVE = 3'b001,
    DAPR_AP_WAIT = 3'b010,
    DAPR_PRECH = 3'b011,
    DAPR_REFRESH = 3'b100
  } dapr_state_type;
endpackage

//--- hdl/dapr_cmd_if.sv
`timescale 1ns/10ps
// decoded command toward the bank timers
interface dapr_cmd_if;
  logic act;
  logic rd;
  logic wr;
  logic refresh;
  logic flag;
  logic [2:0] bank;
  modport src (output act, rd, wr, refresh, flag, bank);
  modport dst (input act, rd, wr, refresh, flag, bank);
endinterface

//--- hdl/dapr_bank.sv
`timescale 1ns/10ps
// per-bank auto-precharge timer
module dapr_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // command
  dapr_cmd_if.dst cmd,
  input wire logic [2:0] my_bank,
  // timing in clocks
  input wire logic [3:0] t_ras,
  input wire logic [3:0] t_rtp,
  input wire logic [3:0] t_rp,
  input wire logic [3:0] t_rfc,
  input wire logic [3:0] ap_rd_delay,
  input wire logic [4:0] ap_wr_delay,
  // state
  output logic open_bank,
  output logic precharging
);
  import dapr_pkg::*;
  dapr_state_type state_reg;
  logic [4:0] ras_cnt_reg;
  logic [4:0] rtp_cnt_reg;
  logic [4:0] wait_cnt_reg;
  logic sel;
  assign sel = (cmd.bank == my_bank);
  assign open_bank = (state_reg == DAPR_ACTIVE) || (state_reg == DAPR_AP_WAIT);
  assign precharging = (state_reg == DAPR_PRECH) || (state_reg == DAPR_REFRESH);
  // row-active and read-to-precharge age counters
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ras_cnt_reg <= 5'h00;
      rtp_cnt_reg <= 5'h00;
    end else begin
      if (cmd.act && sel) begin
        ras_cnt_reg <= 5'h01;
      end else if (ras_cnt_reg != 5'h1f) begin
        ras_cnt_reg <= ras_cnt_reg + 5'h01;
      end
      if (cmd.rd && sel) begin
        rtp_cnt_reg <= 5'h01;
      end else if (rtp_cnt_reg != 5'h1f) begin
        rtp_cnt_reg <= rtp_cnt_reg + 5'h01;
      end
    end
  end
  // bank state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= DAPR_IDLE;
      wait_cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        DAPR_IDLE: begin
          if (cmd.refresh) begin
            state_reg <= DAPR_REFRESH;
            wait_cnt_reg <= {1'b0, t_rfc};
          end else if (cmd.act && sel) begin
            state_reg <= DAPR_ACTIVE;
          end
        end
        DAPR_ACTIVE: begin
          if ((cmd.rd || cmd.wr) && sel && cmd.flag) begin // RL1
            state_reg <= DAPR_AP_WAIT;
            wait_cnt_reg <= cmd.rd ? {1'b0, ap_rd_delay} : ap_wr_delay; // RL2 RL8
          end
        end
        DAPR_AP_WAIT: begin
          if (wait_cnt_reg > 5'h01) begin
            wait_cnt_reg <= wait_cnt_reg - 5'h01;
          end else if ((ras_cnt_reg >= {1'b0, t_ras}) && (rtp_cnt_reg >= {1'b0, t_rtp})) begin
            // lockout until row restore and read-to-precharge met
            state_reg <= DAPR_PRECH; // RL3 RL12
            wait_cnt_reg <= {1'b0, t_rp}; // RL4
          end
        end
        DAPR_PRECH: begin
          if (wait_cnt_reg > 5'h01) begin
            wait_cnt_reg <= wait_cnt_reg - 5'h01;
          end else begin
            state_reg <= DAPR_IDLE;
          end
        end
        DAPR_REFRESH: begin
          if (wait_cnt_reg > 5'h01) begin
            wait_cnt_reg <= wait_cnt_reg - 5'h01;
          end else begin
            state_reg <= DAPR_IDLE; // RL20
          end
        end
        default: begin
          state_reg <= DAPR_IDLE;
        end
      endcase
    end
  end
endmodule

//--- hdl/dapr_top.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RL1: flag high with read/write closes bank
// RL2: read precharge at AL plus BL/2
// RL3: postpone until row-active and read-precharge met
// RL4: precharge period counts from actual start
// RL5: controller waits AL+tRTP+tRP before activate
// RL6: precharge never before two clocks after prefetch
// RL7: reactivate only after tRP and tRC
// RL8: write precharge after burst plus recovery
// RL9: controller waits WR+tRP and tRC
// RL10: write recovery setting limited 2 to 6
// RL11: write-to-activate spacing WL+BL/2+tDAL
// RL12: lockout delays precharge until restore completes
// RL13: other banks accept non-interrupting commands
// RL14: write-AP to other bank spacing
// RL15: read-AP to other bank spacing
// RL16: controller refreshes all rows in 64 ms
// RL17: refresh decode CS RAS CAS low WE high
// RL18: refresh uses internal row counter
// RL19: refresh only after banks idle tRP
// RL20: after refresh banks idle, wait tRFC
// RL21: up to eight refreshes may be postponed
// RL22: each refresh command does one row
module dapr_top #(
  parameter int ROW_BITS = 14,
  parameter int REFI_CYCLES = dapr_pkg::DAPR_REFI_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // status
  output logic [7:0] bank_open,
  output logic [7:0] bank_prech,
  output logic [ROW_BITS-1:0] refresh_row,
  output logic refresh_late
);
  import dapr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic ph_valid_reg;
  logic ph_write_reg;
  logic [7:0] ph_addr_reg;
  logic [15:0] timing_reg;
  logic [15:0] mode_reg;
  logic [7:0] cmd_byte;
  logic cmd_fire;
  logic [7:0] open_w;
  logic [7:0] prech_w;
  logic [ROW_BITS-1:0] row_reg;
  logic [3:0] late_cnt_reg;
  logic [31:0] refi_cnt_reg;
  dapr_cmd_if cmd_bus ();

  // limit write recovery to its legal range
  function automatic logic [3:0] clamp_wr(input logic [3:0] v);
    if (v < DAPR_WR_MIN) begin
      return DAPR_WR_MIN;
    end else if (v > DAPR_WR_MAX) begin
      return DAPR_WR_MAX;
    end
    return v;
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready) begin
      ph_valid_reg <= hsel && htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  // zero-wait okay responses
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write data phase
  assign cmd_fire = ph_valid_reg && ph_write_reg && (ph_addr_reg == DAPR_OFF_CMD);
  assign cmd_byte = hwdata[7:0];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timing_reg <= DAPR_TIMING_RST;
      mode_reg <= DAPR_MODE_RST;
    end else if (ph_valid_reg && ph_write_reg) begin
      if (ph_addr_reg == DAPR_OFF_TIMING) begin
        timing_reg <= hwdata[15:0];
      end
      if (ph_addr_reg == DAPR_OFF_MODE) begin
        mode_reg <= {clamp_wr(hwdata[15:12]), hwdata[11:0]}; // RL10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode from pin levels
  always_comb begin
    cmd_bus.act = 1'b0;
    cmd_bus.rd = 1'b0;
    cmd_bus.wr = 1'b0;
    cmd_bus.refresh = 1'b0;
    cmd_bus.flag = cmd_byte[DAPR_CMD_FLAG_POS];
    cmd_bus.bank = cmd_byte[DAPR_CMD_BANK_LSB +: 3];
    if (cmd_fire && !cmd_byte[DAPR_CMD_CS_N_POS]) begin
      case (cmd_byte[DAPR_CMD_WE_N_POS -: 3])
        3'b100: cmd_bus.refresh = 1'b1; // RL17
        3'b110: cmd_bus.act = 1'b1;
        3'b101: cmd_bus.rd = 1'b1;
        3'b001: cmd_bus.wr = 1'b1;
        default: cmd_bus.act = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // auto-precharge delays from mode fields
  logic [3:0] al_w;
  logic [3:0] wl_w;
  logic [3:0] half_bl;
  logic [3:0] rd_delay;
  logic [4:0] wr_delay;
  assign al_w = mode_reg[DAPR_MODE_AL_LSB +: 4];
  assign wl_w = mode_reg[DAPR_MODE_WL_LSB +: 4];
  assign half_bl = mode_reg[DAPR_MODE_BL8_POS] ? 4'h4 : 4'h2;
  // read: al + bl/2, at least two clocks after last prefetch
  assign rd_delay = al_w + half_bl + (mode_reg[DAPR_MODE_BL8_POS] ? 4'h0 : 4'h0)
                    + ((half_bl < DAPR_PREFETCH_GAP) ? DAPR_PREFETCH_GAP : 4'h0); // RL6
  // write: wl + bl/2 + wr
  assign wr_delay = {1'b0, wl_w} + {1'b0, half_bl} + {1'b0, mode_reg[DAPR_MODE_WR_LSB +: 4]}; // RL8

  // one timer per bank, other banks keep working
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bank
      dapr_bank u_bank (
        .clock(clock),
        .rst_n(rst_n),
        .cmd(cmd_bus),
        .my_bank(3'(gi)),
        .t_ras(timing_reg[DAPR_TIM_RAS_LSB +: 4]),
        .t_rtp(timing_reg[DAPR_TIM_RTP_LSB +: 4]),
        .t_rp(timing_reg[DAPR_TIM_RP_LSB +: 4]),
        .t_rfc(timing_reg[DAPR_TIM_RFC_LSB +: 4]),
        .ap_rd_delay(rd_delay),
        .ap_wr_delay(wr_delay),
        .open_bank(open_w[gi]),
        .precharging(prech_w[gi])
      ); // RL13
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // internal refresh row counter, address pins ignored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      row_reg <= '0;
    end else if (cmd_bus.refresh) begin
      row_reg <= row_reg + ROW_BITS'(1); // RL18 RL22
    end
  end

  // refresh interval monitor counting postponed refreshes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refi_cnt_reg <= 32'h0;
      late_cnt_reg <= 4'h0;
    end else if (cmd_bus.refresh) begin
      refi_cnt_reg <= 32'h0;
      late_cnt_reg <= 4'h0;
    end else if (refi_cnt_reg >= 32'(REFI_CYCLES - 1)) begin
      refi_cnt_reg <= 32'h0;
      if (late_cnt_reg != 4'hf) begin
        late_cnt_reg <= late_cnt_reg + 4'h1; // RL21
      end
    end else begin
      refi_cnt_reg <= refi_cnt_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs and read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bank_open <= 8'h00;
      bank_prech <= 8'h00;
      refresh_row <= '0;
      refresh_late <= 1'b0;
    end else begin
      bank_open <= open_w;
      bank_prech <= prech_w;
      refresh_row <= row_reg;
      refresh_late <= (late_cnt_reg > 4'h8);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        DAPR_OFF_TIMING: hrdata <= {16'h0, timing_reg};
        DAPR_OFF_MODE: hrdata <= {16'h0, mode_reg};
        DAPR_OFF_BANK_STAT: hrdata <= {16'h0, prech_w, open_w};
        DAPR_OFF_REF_ROW: hrdata <= 32'(row_reg);
        DAPR_OFF_REF_CNT: hrdata <= {28'h0, late_cnt_reg};
        default: hrdata <= 32'h0;
      endcase
    end
  end
endmodule

//--- testbench/dapr_chk_props.sv
`timescale 1ns/10ps
// port-level checks on command effects
module dapr_chk #(
  parameter int ROW_BITS = 14
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // status
  input wire logic [7:0] bank_open,
  input wire logic [7:0] bank_prech,
  input wire logic [ROW_BITS-1:0] refresh_row
);
  import dapr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic cw;
  logic [4:0] age0;
  logic [ROW_BITS-1:0] row_at;
  wire logic go = cw && !hwdata[4];
  wire logic act = go && hwdata[7:5] == 3'b110;
  wire logic rd = go && hwdata[7:5] == 3'b101;
  wire logic idle = bank_open == 8'h00 && bank_prech == 8'h00;
  wire logic rf = go && hwdata[7:5] == 3'b100 && idle;
  ////////////////////////////////////////////////////////////////////////
  // data phase of a command word
  always_ff @(posedge clock) begin
    if (!rst_n) cw <= 1'b0;
    else cw <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == DAPR_OFF_CMD;
  end
  // cycles since bank 0 opened
  always_ff @(posedge clock) begin
    if (!rst_n) age0 <= 5'h00;
    else if (act && hwdata[2:0] == 3'h0) age0 <= 5'h00;
    else if (age0 != 5'h1f) age0 <= age0 + 5'h01;
  end
  // row seen when a refresh is taken
  always_ff @(posedge clock) begin
    if (rf) row_at <= refresh_row;
  end
  ////////////////////////////////////////////////////////////////////////
  AST_ACT_OPENS: assert property (act && hwdata[2:0] == 3'h0 |-> ##[1:3] bank_open[0])
    else $error("bank not opened");
  AST_PLAIN_READ: assert property (rd && hwdata[3:0] == 4'h5 && bank_open[5] |-> ##1 bank_open[5] [*8])
    else $error("bank closed without flag");
  AST_AP_GAP: assert property (rd && hwdata[3:0] == 4'h8 |-> ##1 (!bank_prech[0]) [*2])
    else $error("precharge too early");
  AST_AP_RAS: assert property ($rose(bank_prech[0]) && $past(bank_open[0]) |-> age0 >= 5'h08)
    else $error("row active time not met");
  AST_PRECH_ENDS: assert property ($rose(bank_prech[0]) |-> ##[1:20] !bank_prech[0])
    else $error("precharge never ends");
  AST_EXCL: assert property ((bank_open & bank_prech) == 8'h00)
    else $error("bank open while precharging");
  AST_REF_ALL: assert property (rf |-> ##[1:3] bank_prech == 8'hff)
    else $error("refresh not entered");
  AST_REF_ROW: assert property (rf |-> ##[1:3] refresh_row == ROW_BITS'(row_at + 1'b1))
    else $error("refresh row not advanced");
endmodule
bind dapr_top dapr_chk #(.ROW_BITS(ROW_BITS)) dapr_chk_inst (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .bank_open(bank_open),
  .bank_prech(bank_prech), .refresh_row(refresh_row)
);

//--- testbench/dapr_ctrl.sv
`timescale 1ns/10ps
// controller side: issues words over the bus
module dapr_ctrl (
  // clock
  input wire logic clock,
  // bus
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // read results
  output logic rd_seen,
  output logic [31:0] rd_val
);
  import dapr_pkg::*;
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    rd_seen = 1'b0;
    rd_val = 32'h00000000;
  end
  // one single word, each phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hwdata <= ~d;
    rd_val <= hrdata;
    rd_seen <= !wr;
    @(posedge clock);
    rd_seen <= 1'b0;
  endtask
  // command word: op is we_n cas_n ras_n, select held low
  task automatic cmd(input logic [2:0] op, input logic flag, input logic [2:0] bank);
    xfer(1'b1, DAPR_OFF_CMD, {24'h000000, op, 1'b0, flag, bank});
  endtask
endmodule

//--- testbench/test_dram_autoprecharge_refresh.sv
`timescale 1ns/10ps
// bench for auto-precharge and refresh
module test_dram_autoprecharge_refresh;
  import dapr_pkg::*;
  localparam int REFI = 20;
  localparam logic [2:0] ACT = 3'b110;
  localparam logic [2:0] RD = 3'b101;
  localparam logic [2:0] WR = 3'b001;
  localparam logic [2:0] REF = 3'b100;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hready, hresp, refresh_late, rd_seen;
  logic [1:0] htrans;
  logic [2:0] hsize, b;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [7:0] bank_open, bank_prech;
  logic [13:0] refresh_row, r;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  always #10 clock = ~clock;
  dapr_top #(.REFI_CYCLES(REFI)) dapr_top_inst (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .bank_open(bank_open), .bank_prech(bank_prech),
    .refresh_row(refresh_row), .refresh_late(refresh_late)
  );
  dapr_ctrl dapr_ctrl_inst (
    .clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .rd_seen(rd_seen), .rd_val(rd_val)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    dapr_ctrl_inst.xfer(1'b0, a, 32'h0);
  endtask
  // settle after n edges
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // oldest note against each read result
  always @(posedge clock) begin
    if (rd_seen === 1'b1) check(rd_val, exp_q.pop_front());
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(26734));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(DAPR_OFF_TIMING, {16'h0000, DAPR_TIMING_RST});
    rd(DAPR_OFF_MODE, {16'h0000, DAPR_MODE_RST});
    dapr_ctrl_inst.xfer(1'b1, 8'h18, $urandom());
    rd(8'h18, 32'h0);
    // recovery setting held to its range
    for (int w = 0; w < 8; w++) begin
      dapr_ctrl_inst.xfer(1'b1, DAPR_OFF_MODE, {16'h0000, w[3:0], 12'h200});
      rd(DAPR_OFF_MODE, {16'h0000, (w < 2) ? DAPR_WR_MIN : (w > 6) ? DAPR_WR_MAX : w[3:0], 12'h200});
    end
    // burst of eight with additive latency one: precharge at al plus four
    dapr_ctrl_inst.xfer(1'b1, DAPR_OFF_MODE, {16'h0000, 16'h3211});
    rd(DAPR_OFF_MODE, {16'h0000, 16'h3211});
    dapr_ctrl_inst.cmd(ACT, 1'b0, 3'h2);
    wt(12);
    dapr_ctrl_inst.cmd(RD, 1'b1, 3'h2);
    wt(3);
    check({31'h0, bank_open[2]}, 32'h1);
    wt(2);
    check({31'h0, bank_open[2]}, 32'h0);
    check({31'h0, bank_prech[2]}, 32'h1);
    wt(8);
    dapr_ctrl_inst.xfer(1'b1, DAPR_OFF_MODE, {16'h0000, DAPR_MODE_RST});
    // plain read keeps the bank, flagged write closes it
    b = 3'($urandom_range(7));
    dapr_ctrl_inst.cmd(ACT, 1'b0, b);
    wt(3);
    check({31'h0, bank_open[b]}, 32'h1);
    dapr_ctrl_inst.cmd(RD, 1'b0, b);
    wt(12);
    check({31'h0, bank_open[b]}, 32'h1);
    dapr_ctrl_inst.cmd(WR, 1'b1, b);
    wt(2);
    check({31'h0, bank_open[b]}, 32'h1);
    wt(20);
    check({24'h0, bank_open | bank_prech}, 32'h0);
    // flagged read right after opening waits for row active time
    dapr_ctrl_inst.cmd(ACT, 1'b0, 3'h0);
    dapr_ctrl_inst.cmd(RD, 1'b1, 3'h0);
    wt(3);
    check({24'h0, bank_open}, 32'h1);
    dapr_ctrl_inst.cmd(ACT, 1'b0, 3'h5);
    dapr_ctrl_inst.cmd(RD, 1'b0, 3'h5);
    wt(20);
    check({24'h0, bank_open}, 32'h20);
    dapr_ctrl_inst.cmd(WR, 1'b1, 3'h5);
    wt(20);
    // refresh from idle, address ignored
    r = refresh_row;
    dapr_ctrl_inst.cmd(REF, 1'b0, 3'($urandom_range(7)));
    wt(1);
    check({24'h0, bank_prech}, 32'hff);
    check({18'h0, refresh_row}, {18'h0, r + 14'h1});
    wt(12);
    check({24'h0, bank_prech}, 32'h0);
    rd(DAPR_OFF_REF_ROW, {18'h0, r + 14'h1});
    wt(8 * REFI - 30);
    check({31'h0, refresh_late}, 32'h0);
    wt(50);
    check({31'h0, refresh_late}, 32'h1);
    dapr_ctrl_inst.cmd(REF, 1'b0, 3'h0);
    wt(1);
    check({31'h0, refresh_late}, 32'h0);
    print_verdict();
  end
endmodule
